// ### rtl/fsp_consts.svh
// Constants for the flash self-program controller.
// Assumes a 100 MHz system clock and byte addresses on the register bus.
`ifndef FSP_CONSTS_SVH
`define FSP_CONSTS_SVH
`define FSP_CLK_PERIOD_NS 10
`define FSP_MIN_PROG_NS   3700000
`define FSP_MAX_PROG_NS   4500000
`define FSP_SPM_WINDOW    3'h4
`define FSP_OFF_CTRL      5'h00
`define FSP_OFF_PTR       5'h04
`define FSP_OFF_DATA      5'h08
`define FSP_OFF_EXEC      5'h0c
`define FSP_OFF_LOCK      5'h10
`define FSP_PAT_LOAD      7'h01
`define FSP_PAT_ERASE     7'h03
`define FSP_PAT_WRITE     7'h05
`define FSP_PAT_LOCK      7'h09
`define FSP_PAT_REEN      7'h11
`define FSP_BIT_SELF_PROG_ENABLE_BIT     0
`define FSP_BIT_BUSY      6
`define FSP_BIT_IE        7
`define FSP_WORD_MSB      6
`define FSP_PAGE_LSB      7
`define FSP_HALT_PAGE     9'h1c0
`define FSP_APP_VECTOR    15'h0000
`define FSP_BOOT_VECTOR   15'h3800
`define FSP_LOCK_RST      6'h3f
`define FSP_BUF_ERASED    16'hffff
`endif

// ### rtl/fsp_pkg.sv
// Types for the flash self-program controller.
// Assumes the constants header is compiled alongside.
package fsp_pkg;
  typedef enum logic [2:0] {
    FSP_IDLE  = 3'b001,
    FSP_ARMED = 3'b010,
    FSP_BUSY  = 3'b100
  } fsp_state_t;
  typedef struct packed {
    logic       erase;
    logic       write;
    logic       lock;
    logic [8:0] page;
  } fsp_flash_cmd_t;
endpackage

// ### rtl/fsp_ctrl.sv
// Flash self-program sequencer with an Avalon-MM register slave.
// Assumes fuse and EEPROM status arrive as asynchronous pins.
//
// Operation
// - Reset vector follows boot reset fuse.
// - Processor has no path to fuses.
// - Pointer splits into page and word fields.
// - Target page latched at operation start.
// - Lock setting ignores the pointer.
// - Pointer bit zero selects read byte.
// - Erase pattern plus store within four cycles.
// - Halting-region programming stalls the CPU.
// - Load pattern stores data word into buffer.
// - Buffer cleared on write, re-enable, reset.
// - EEPROM write discards loaded buffer data.
// - Write pattern plus store starts page write.
// - Interrupt level while enable bit clear.
// - Busy flag set during erase or write.
// - Lock pattern programs zero bits of data.
// - Lock programming blocks no reads.
// - EEPROM write blocks programming and lock reads.
// - Enable bit auto-clears without store command.
// - Each erase, write or lock timed at least 3.7 ms.
//
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
`include "fsp_consts.svh"
module fsp_ctrl #(
  parameter int OP_CYCLES =
    (`FSP_MIN_PROG_NS + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS
) (
  // Clock and reset.
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  // Avalon-MM register slave.
  input  wire logic [4:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  // Asynchronous status pins.
  input  wire logic                  boot_reset_fuse,
  input  wire logic                  eeprom_write_active_flag,
  // Core side.
  output logic      [14:0]           reset_vector,
  output logic                       cpu_stall,
  output logic                       rww_read_block,
  output logic                       spm_irq,
  output logic      [14:0]           prog_rd_word,
  output logic                       prog_rd_byte_sel,
  // Flash array side.
  output fsp_pkg::fsp_flash_cmd_t    flash_cmd,
  input  wire logic [5:0]            flash_buf_idx,
  output logic      [15:0]           flash_buf_data,
  output logic      [5:0]            lock_bits
);
  localparam logic [18:0] OP_LAST = 19'(OP_CYCLES - 1);

  fsp_pkg::fsp_state_t state_reg;
  logic [1:0]  fuse_sync_reg;
  logic [1:0]  ee_sync_reg;
  logic        bus_ack_reg;
  logic [6:0]  cmd_reg;
  logic        ie_reg;
  logic        busy_flag_reg;
  logic [15:0] ptr_reg;
  logic [15:0] data_reg;
  logic [2:0]  win_reg;
  logic [18:0] timer_reg;
  logic [63:0] buf_valid_reg;
  logic [15:0] buf_mem [0:63];
  logic [8:0]  page_lat_reg;
  logic        wr_acc;
  logic        rd_acc;
  logic        exec_hit;
  logic        ee_active;

  // Page field of a pointer value.
  function automatic logic [8:0] page_of(input logic [15:0] p);
    page_of = p[15:`FSP_PAGE_LSB];
  endfunction

  // Word-in-page field of a pointer value.
  function automatic logic [5:0] word_of(input logic [15:0] p);
    word_of = p[`FSP_WORD_MSB:1];
  endfunction

  // Write access takes effect on the cycle the wait is released.
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack_reg;
  assign wr_acc    = avs_write & bus_ack_reg;
  // Read data is captured in the wait cycle, so it stands at release.
  assign rd_acc    = avs_read & ~bus_ack_reg;
  assign ee_active = ee_sync_reg[1];
  assign exec_hit  = wr_acc && avs_address == `FSP_OFF_EXEC &&
                     state_reg == fsp_pkg::FSP_ARMED && !ee_active;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bus_ack_reg <= 1'b0;
    end else begin
      bus_ack_reg <= (avs_read | avs_write) & ~bus_ack_reg;
    end
  end

  // Two-stage synchronisers for the pins.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fuse_sync_reg <= 2'h3;
      ee_sync_reg   <= 2'h0;
    end else begin
      fuse_sync_reg <= {fuse_sync_reg[0], boot_reset_fuse};
      ee_sync_reg   <= {ee_sync_reg[0], eeprom_write_active_flag};
    end
  end

  // Fuse is read only; nothing here can change it.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reset_vector <= `FSP_APP_VECTOR;
    end else begin
      reset_vector <= fuse_sync_reg[1] ? `FSP_APP_VECTOR
                                       : `FSP_BOOT_VECTOR;
    end
  end

  // Pointer and data word registers.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ptr_reg  <= 16'h0000;
      data_reg <= 16'h0000;
    end else if (wr_acc) begin
      if (avs_address == `FSP_OFF_PTR) begin
        ptr_reg <= avs_writedata[15:0];
      end
      if (avs_address == `FSP_OFF_DATA) begin
        data_reg <= avs_writedata[15:0];
      end
    end
  end

  // Byte reads address flash byte by byte.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prog_rd_word     <= 15'h0000;
      prog_rd_byte_sel <= 1'b0;
    end else begin
      prog_rd_word     <= ptr_reg[15:1];
      prog_rd_byte_sel <= ptr_reg[0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ie_reg <= 1'b0;
    end else if (wr_acc && avs_address == `FSP_OFF_CTRL) begin
      ie_reg <= avs_writedata[`FSP_BIT_IE];
    end
  end

  // Command sequencer.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg    <= fsp_pkg::FSP_IDLE;
      cmd_reg      <= 7'h00;
      win_reg      <= 3'h0;
      timer_reg    <= 19'h00000;
      page_lat_reg <= 9'h000;
    end else begin
      case (state_reg)
        fsp_pkg::FSP_IDLE: begin
          if (wr_acc && avs_address == `FSP_OFF_CTRL && !ee_active &&
              avs_writedata[`FSP_BIT_SELF_PROG_ENABLE_BIT]) begin
            state_reg <= fsp_pkg::FSP_ARMED;
            cmd_reg   <= avs_writedata[6:0];
            win_reg   <= `FSP_SPM_WINDOW;
          end
        end
        fsp_pkg::FSP_ARMED: begin
          win_reg <= win_reg - 3'h1;
          if (exec_hit) begin
            if (cmd_reg == `FSP_PAT_ERASE || cmd_reg == `FSP_PAT_WRITE ||
                cmd_reg == `FSP_PAT_LOCK) begin
              state_reg    <= fsp_pkg::FSP_BUSY;
              timer_reg    <= OP_LAST;
              page_lat_reg <= page_of(ptr_reg);
            end else begin
              state_reg <= fsp_pkg::FSP_IDLE;
              cmd_reg   <= 7'h00;
            end
          end else if (win_reg == 3'h1 || ee_active) begin
            state_reg <= fsp_pkg::FSP_IDLE;
            cmd_reg   <= 7'h00;
          end
        end
        fsp_pkg::FSP_BUSY: begin
          timer_reg <= timer_reg - 19'h00001;
          if (timer_reg == 19'h00000) begin
            state_reg <= fsp_pkg::FSP_IDLE;
            cmd_reg   <= 7'h00;
          end
        end
        default: begin
          state_reg <= fsp_pkg::FSP_IDLE;
        end
      endcase
    end
  end

  // Flash command pulse; the page field is registered from the pointer every cycle.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flash_cmd <= '0;
    end else begin
      flash_cmd.erase <= exec_hit && cmd_reg == `FSP_PAT_ERASE;
      flash_cmd.write <= exec_hit && cmd_reg == `FSP_PAT_WRITE;
      flash_cmd.lock  <= exec_hit && cmd_reg == `FSP_PAT_LOCK;
      flash_cmd.page  <= page_of(ptr_reg);
    end
  end

  // Lock bits take only the data word, never the pointer.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      lock_bits <= `FSP_LOCK_RST;
    end else if (exec_hit && cmd_reg == `FSP_PAT_LOCK) begin
      lock_bits <= lock_bits & data_reg[5:0];
    end
  end

  // Busy flag: set by erase or write, cleared only by re-enable or reset.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      busy_flag_reg <= 1'b0;
    end else if (exec_hit && (cmd_reg == `FSP_PAT_ERASE ||
                              cmd_reg == `FSP_PAT_WRITE)) begin
      busy_flag_reg <= 1'b1;
    end else if (exec_hit && cmd_reg == `FSP_PAT_REEN) begin
      busy_flag_reg <= 1'b0;
    end
  end

  // Temporary page buffer.
  always_ff @(posedge clk_sys) begin
    if (exec_hit && cmd_reg == `FSP_PAT_LOAD) begin
      buf_mem[word_of(ptr_reg)] <= data_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || ee_active) begin
      buf_valid_reg <= 64'h0;
    end else if (exec_hit && cmd_reg == `FSP_PAT_REEN) begin
      buf_valid_reg <= 64'h0;
    end else if (state_reg == fsp_pkg::FSP_BUSY &&
                 timer_reg == 19'h00000 && cmd_reg == `FSP_PAT_WRITE) begin
      buf_valid_reg <= 64'h0;
    end else if (exec_hit && cmd_reg == `FSP_PAT_LOAD) begin
      buf_valid_reg[word_of(ptr_reg)] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flash_buf_data <= `FSP_BUF_ERASED;
    end else begin
      flash_buf_data <= buf_valid_reg[flash_buf_idx] ?
                        buf_mem[flash_buf_idx] : `FSP_BUF_ERASED;
    end
  end

  // Halting-region programming stalls; lock programming never does.
  assign cpu_stall = state_reg == fsp_pkg::FSP_BUSY &&
                     cmd_reg != `FSP_PAT_LOCK &&
                     page_lat_reg >= `FSP_HALT_PAGE;
  assign rww_read_block = busy_flag_reg;
  assign spm_irq = ie_reg && state_reg == fsp_pkg::FSP_IDLE;

  // Register read port.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0;
    end else if (rd_acc) begin
      case (avs_address)
        `FSP_OFF_CTRL: avs_readdata <= {24'h0, ie_reg, busy_flag_reg,
                                        cmd_reg[5:1],
                                        state_reg != fsp_pkg::FSP_IDLE};
        `FSP_OFF_PTR:  avs_readdata <= {16'h0, ptr_reg};
        `FSP_OFF_DATA: avs_readdata <= {16'h0, data_reg};
        `FSP_OFF_LOCK: avs_readdata <= ee_active ? 32'h0 :
                                       {26'h0, lock_bits};
        default:       avs_readdata <= 32'h0;
      endcase
    end
  end

  arm_timeout_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state_reg == fsp_pkg::FSP_ARMED && win_reg == 3'h1 && !exec_hit
    |=> state_reg == fsp_pkg::FSP_IDLE)
    else $error("enable bit did not auto-clear");
  page_latch_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state_reg == fsp_pkg::FSP_BUSY && $past(state_reg) ==
    fsp_pkg::FSP_BUSY |-> $stable(page_lat_reg))
    else $error("latched page moved during operation");
  erase_busy_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    exec_hit && cmd_reg == `FSP_PAT_ERASE
    |=> busy_flag_reg && flash_cmd.erase &&
        state_reg == fsp_pkg::FSP_BUSY)
    else $error("erase did not start");
  irq_level_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state_reg == fsp_pkg::FSP_BUSY && timer_reg == 19'h00000 && ie_reg &&
    !(wr_acc && avs_address == `FSP_OFF_CTRL)
    |=> spm_irq)
    else $error("interrupt level wrong");
  buf_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    exec_hit && cmd_reg == `FSP_PAT_REEN
    |=> buf_valid_reg == 64'h0 && !busy_flag_reg)
    else $error("re-enable did not clear buffer");
  ee_block_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ee_active && state_reg == fsp_pkg::FSP_IDLE
    |=> state_reg == fsp_pkg::FSP_IDLE)
    else $error("programming armed during EEPROM write");
  lock_nostall_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state_reg == fsp_pkg::FSP_BUSY && cmd_reg == `FSP_PAT_LOCK
    |-> !cpu_stall && !rww_read_block)
    else $error("lock programming blocked reads");
  op_length_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(state_reg == fsp_pkg::FSP_BUSY) |-> timer_reg == OP_LAST
    ##1 state_reg == fsp_pkg::FSP_BUSY)
    else $error("operation time wrong");
  load_store_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    exec_hit && cmd_reg == `FSP_PAT_LOAD
    |=> buf_valid_reg[$past(ptr_reg[6:1])] &&
        state_reg == fsp_pkg::FSP_IDLE)
    else $error("page load not stored");
  boot_vec_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !fuse_sync_reg[1] |=> reset_vector == `FSP_BOOT_VECTOR)
    else $error("reset vector does not follow fuse");
endmodule

// ### dv/fsp_flash_model.sv
// Flash array stand-in that picks buffer words and counts commands.
// Assumes one system clock and the controller's command struct.
`timescale 1ns/100ps
module fsp_flash_model (
  // Clock and reset.
  input  wire logic                    clk_sys,
  input  wire logic                    sys_rst,
  // Controller side.
  input  wire fsp_pkg::fsp_flash_cmd_t flash_cmd,
  output logic      [5:0]              flash_buf_idx,
  // Bench side.
  input  wire logic [5:0]              idx_req,
  output int                           n_cmd,
  output logic      [8:0]              last_page
);
  assign flash_buf_idx = idx_req;
  // Every cycle a pulse is high counts, so a stretched pulse shows.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      n_cmd <= 0;
    end else if (flash_cmd.erase | flash_cmd.write | flash_cmd.lock) begin
      n_cmd     <= n_cmd + 1;
      last_page <= flash_cmd.page;
    end
  end
endmodule

// ### dv/tb.sv
// Self-checking bench for the flash self-program controller.
// Assumes a 100 MHz clock and a short operation count.
`timescale 1ns/100ps
`include "fsp_consts.svh"
module tb;
  logic        clk_sys, sys_rst, avs_read, avs_write, fuse, ee;
  logic        avs_waitrequest, cpu_stall, rww_read_block, spm_irq, bsel;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [14:0] reset_vector, prog_rd_word;
  logic [5:0]  flash_buf_idx, lock_bits, idx, lk;
  logic [15:0] d, p;
  logic [15:0] flash_buf_data;
  logic [8:0]  last_page, pg;
  fsp_pkg::fsp_flash_cmd_t flash_cmd;
  int          failures, n_tests, n_cmd, n0;
  fsp_ctrl #(.OP_CYCLES(20)) fsp_ctrl_i (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .boot_reset_fuse(fuse), .eeprom_write_active_flag(ee),
    .reset_vector(reset_vector), .cpu_stall(cpu_stall),
    .rww_read_block(rww_read_block), .spm_irq(spm_irq),
    .prog_rd_word(prog_rd_word), .prog_rd_byte_sel(bsel),
    .flash_cmd(flash_cmd), .flash_buf_idx(flash_buf_idx),
    .flash_buf_data(flash_buf_data), .lock_bits(lock_bits));
  fsp_flash_model fsp_flash_model_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .flash_cmd(flash_cmd), .flash_buf_idx(flash_buf_idx), .idx_req(idx),
    .n_cmd(n_cmd), .last_page(last_page));
  function automatic logic [14:0] f_vec(input logic f);
    return f ? `FSP_APP_VECTOR : `FSP_BOOT_VECTOR;
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask
  task automatic acc(input logic [4:0] a, input logic [31:0] wd,
                     input logic w);
    int i;
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= w;
    avs_read      <= !w;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      failures++;
      results();
    end
    q = avs_readdata;
  endtask
  task automatic rel(input int n);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic spm(input logic [6:0] pat, input logic [15:0] ptr, dt);
    acc(`FSP_OFF_PTR, {16'h0, ptr}, 1'b1);
    acc(`FSP_OFF_DATA, {16'h0, dt}, 1'b1);
    acc(`FSP_OFF_CTRL, {24'h0, 1'b1, pat}, 1'b1);
    acc(`FSP_OFF_EXEC, 32'h0, 1'b1);
  endtask
  task automatic wait_done();
    int i;
    for (i = 0; i < 100; i++) begin
      acc(`FSP_OFF_CTRL, 32'h0, 1'b0);
      if (q[0] === 1'b0) break;
    end
    if (i == 100) begin
      failures++;
      results();
    end
  endtask
  task automatic buf_is(input logic [5:0] w, input logic [15:0] e);
    idx <= w;
    repeat (2) @(posedge clk_sys);
    chk("buffer", {16'h0, e}, {16'h0, flash_buf_data});
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    {sys_rst, fuse, avs_read, avs_write, ee} = 5'h18;
    {avs_address, avs_writedata, idx, failures, n_tests} = '0;
    lk = `FSP_LOCK_RST;
    void'($urandom(32'hcb64));
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("vector", f_vec(fuse), reset_vector);
    chk("locks", lk, lock_bits);
    fuse <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk("vector", f_vec(1'b0), reset_vector);
    acc(5'h14, 32'h0, 1'b0);
    chk("unmapped", 32'h0, q);
    for (int k = 0; k < 4; k++) begin
      p = $urandom;
      acc(`FSP_OFF_PTR, {16'h0, p}, 1'b1);
      rel(2);
      chk("word", p[15:1], prog_rd_word);
      chk("byte", p[0], bsel);
    end
    $display("test reset and pointer done");
    for (int k = 0; k < 4; k++) begin
      d = $urandom;
      spm(`FSP_PAT_LOAD, {9'h0, 6'(k * 9), 1'b0}, d);
      rel(1);
      buf_is(6'(k * 9), d);
    end
    buf_is(6'h3f, `FSP_BUF_ERASED);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    buf_is(6'd9, `FSP_BUF_ERASED);
    $display("test load done");
    pg = 9'($urandom % 448);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) pg = 9'h1c0 | 9'($urandom % 64);
      n0 = n_cmd;
      d = $urandom;
      spm(`FSP_PAT_LOAD, 16'h0004, d);
      spm(k == 1 ? `FSP_PAT_WRITE : `FSP_PAT_ERASE, {pg, 7'h0}, 0);
      acc(`FSP_OFF_PTR, 32'h0, 1'b1);
      rel(3);
      chk("pulse", n0 + 1, n_cmd);
      chk("page", pg, last_page);
      chk("stall", k == 2, cpu_stall);
      chk("block", 1'b1, rww_read_block);
      chk("irq", 1'b0, spm_irq);
      wait_done();
      chk("flag", 1'b1, q[6]);
      rel(1);
      chk("irq", 1'b1, spm_irq);
      buf_is(6'd2, k == 1 ? `FSP_BUF_ERASED : d);
      spm(`FSP_PAT_REEN, 0, 0);
      rel(2);
      chk("block", 1'b0, rww_read_block);
      buf_is(6'd2, `FSP_BUF_ERASED);
    end
    $display("test erase and write done");
    d = {8'h0, 2'h3, 6'($urandom)};
    spm(`FSP_PAT_LOCK, 16'($urandom), d);
    rel(3);
    lk = lk & d[5:0];
    chk("locks", lk, lock_bits);
    chk("block", 1'b0, rww_read_block | cpu_stall);
    wait_done();
    acc(`FSP_OFF_LOCK, 32'h0, 1'b0);
    chk("lockread", lk, q);
    n0 = n_cmd;
    acc(`FSP_OFF_CTRL, {25'h1, `FSP_PAT_ERASE}, 1'b1);
    rel(6);
    acc(`FSP_OFF_CTRL, 32'h0, 1'b0);
    chk("enable", 1'b0, q[0]);
    acc(`FSP_OFF_EXEC, 32'h0, 1'b1);
    rel(3);
    chk("pulse", n0, n_cmd);
    $display("test lock and window done");
    spm(`FSP_PAT_LOAD, 16'h0006, 16'h1234);
    ee <= 1'b1;
    rel(5);
    buf_is(6'd3, `FSP_BUF_ERASED);
    spm(`FSP_PAT_ERASE, 0, 0);
    rel(3);
    chk("pulse", n0, n_cmd);
    acc(`FSP_OFF_LOCK, 32'h0, 1'b0);
    chk("lockread", 32'h0, q);
    ee <= 1'b0;
    rel(2);
    chk("vector", f_vec(1'b0), reset_vector);
    $display("test eeprom done");
    results();
  end
endmodule
